// File: core/psu_regs_defines.svh
// Offsets, field positions, widths and reset values of the supply registers
`ifndef PSU_REGS_DEFINES_SVH
`define PSU_REGS_DEFINES_SVH

`define OFS_STATUS        8'h30
`define OFS_CORE_LEVEL    8'h34
`define OFS_PLL_LEVEL     8'h40
`define OFS_IRQ_STATUS    8'h44
`define OFS_IRQ_MASK      8'h48

`define BIT_OSC_STABLE    24
`define BIT_PLL_GOOD      19
`define BIT_CORE_GOOD     16
`define BIT_ANA_ILIM      9
`define BIT_CORE_ILIM     8
`define BIT_ANA_SOFT      1
`define BIT_CORE_SOFT     0

`define STATUS_MASK       32'h0109_0303
`define CORE_LEVEL_W      7
`define PLL_LEVEL_W       3
`define CORE_LEVEL_MAX    7'h46
`define CORE_LEVEL_RST    7'h28
`define PLL_LEVEL_RST     3'h4
`define IRQ_MASK_RST      32'h0000_0000

`endif

// File: core/psu_regs_pkg.sv
// Types shared by the supply register bank
package psu_regs_pkg;
    typedef struct packed {
        logic osc_stable;
        logic pll_rail_good;
        logic core_rail_good;
        logic analogue_buck_converter_ilim;
        logic core_buck_converter_ilim;
        logic analogue_buck_converter_soft;
        logic core_buck_converter_soft;
    } supply_flags_type;

    typedef struct packed {
        logic       read;
        logic       write;
        logic [7:0] address;
        logic [31:0] writedata;
    } avmm_req_type;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_DONE
    } bus_state_type;
endpackage : psu_regs_pkg

// File: core/flag_sync.sv
// Two-stage synchroniser for the asynchronous supply status flags
`timescale 1ns/1ps
`default_nettype none
module flag_sync
    import psu_regs_pkg::*;
(
    input  wire logic             i_clk_sys,
    input  wire logic             i_resetn,
    input  wire supply_flags_type i_flags,
    output var  supply_flags_type o_flags
);
    supply_flags_type meta_ff;
    supply_flags_type sync_ff;

    // First stage feeds only the second stage
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= i_flags;
            sync_ff <= meta_ff;
        end
    end

    assign o_flags = sync_ff;
endmodule : flag_sync
`default_nettype wire

// File: core/strap_capture.sv
// Synchronises the mode straps and marks when they have settled after reset release
`timescale 1ns/1ps
`default_nettype none
module strap_capture (
    input  wire logic       i_clk_sys,
    input  wire logic       i_resetn,
    input  wire logic [3:0] i_mode_strap,
    output logic [3:0]      o_strap,
    output logic            o_strap_valid
);
    logic [3:0] meta_ff;
    logic [3:0] sync_ff;
    logic [1:0] wait_ff;

    // Synchroniser, then a short wait before the straps count as settled
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            meta_ff <= 4'h0;
            sync_ff <= 4'h0;
            wait_ff <= 2'h0;
        end else begin
            meta_ff <= i_mode_strap;
            sync_ff <= meta_ff;
            if (wait_ff != 2'h3) begin
                wait_ff <= wait_ff + 2'h1;
            end
        end
    end

    // Valid for one cycle exactly when the synchronised straps are fresh
    assign o_strap       = sync_ff;
    assign o_strap_valid = (wait_ff == 2'h2);
endmodule : strap_capture
`default_nettype wire

// File: core/power_supply_status_level_regs.sv
// Supply status and level registers on an Avalon-MM slave with interrupt
`timescale 1ns/1ps
`default_nettype none
`include "psu_regs_defines.svh"

////////////////////////////////////////////////////////////////////////////////
module power_supply_status_level_regs
    import psu_regs_pkg::*;
(
    input  wire logic             i_clk_sys,
    input  wire logic             i_resetn,
    input  wire logic [7:0]       i_avs_address,
    input  wire logic             i_avs_read,
    input  wire logic             i_avs_write,
    input  wire logic [31:0]      i_avs_writedata,
    input  wire logic [3:0]       i_avs_byteenable,
    output logic [31:0]           o_avs_readdata,
    output logic                  o_avs_waitrequest,
    input  wire supply_flags_type i_supply_flags,
    input  wire logic [3:0]       i_mode_strap,
    output logic [6:0]            o_core_rail_level,
    output logic [2:0]            o_pll_rail_level,
    output logic                  o_irq
);
    supply_flags_type flags;
    supply_flags_type flags_d_ff;
    logic [3:0]       strap;
    logic             strap_valid;
    bus_state_type    bus_ff;
    logic [31:0]      readdata_ff;
    logic [6:0]       core_level_ff;
    logic [2:0]       pll_level_ff;
    logic [31:0]      irq_status_ff;
    logic [31:0]      irq_mask_ff;
    logic [31:0]      status_word;
    logic [31:0]      rise_events;
    logic             wr_take;
    logic             rd_take;

    ////////////////////////////////////////////////////////////////////////////
    // Pack flags into the documented layout; everything else is zero
    function automatic logic [31:0] pack_status(input supply_flags_type f);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`BIT_OSC_STABLE] = f.osc_stable;
        w[`BIT_PLL_GOOD]   = f.pll_rail_good;
        w[`BIT_CORE_GOOD]  = f.core_rail_good;
        w[`BIT_ANA_ILIM]   = f.analogue_buck_converter_ilim;
        w[`BIT_CORE_ILIM]  = f.core_buck_converter_ilim;
        w[`BIT_ANA_SOFT]   = f.analogue_buck_converter_soft;
        w[`BIT_CORE_SOFT]  = f.core_buck_converter_soft;
        return w;
    endfunction : pack_status

    // Core default from straps, clamped into the defined code range
    function automatic logic [6:0] core_default(input logic [3:0] s);
        logic [6:0] c;
        c = `CORE_LEVEL_RST + {1'b0, s[1:0], 4'h0};
        if (c > `CORE_LEVEL_MAX) begin
            c = `CORE_LEVEL_MAX;
        end
        return c;
    endfunction : core_default

    // Codes beyond 70 are undefined, so writes above saturate
    function automatic logic [6:0] core_clamp(input logic [6:0] c);
        return (c > `CORE_LEVEL_MAX) ? `CORE_LEVEL_MAX : c;
    endfunction : core_clamp

    ////////////////////////////////////////////////////////////////////////////
    flag_sync u_flag_sync (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_flags   (i_supply_flags),
        .o_flags   (flags)
    );

    strap_capture u_strap_capture (
        .i_clk_sys     (i_clk_sys),
        .i_resetn      (i_resetn),
        .i_mode_strap  (i_mode_strap),
        .o_strap       (strap),
        .o_strap_valid (strap_valid)
    );

    assign status_word = pack_status(flags);

    ////////////////////////////////////////////////////////////////////////////
    // Bus handshake: one wait cycle, answer on the second edge
    assign wr_take = i_avs_write && (bus_ff == BUS_IDLE);
    assign rd_take = i_avs_read && (bus_ff == BUS_IDLE);
    assign o_avs_waitrequest = (i_avs_read || i_avs_write)
                             && (bus_ff == BUS_IDLE);

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            bus_ff <= BUS_IDLE;
        end else begin
            case (bus_ff)
                BUS_IDLE: begin
                    if (i_avs_read || i_avs_write) begin
                        bus_ff <= BUS_DONE;
                    end
                end
                BUS_DONE: bus_ff <= BUS_IDLE;
                default:  bus_ff <= BUS_IDLE;
            endcase
        end
    end

    // Read mux registered in the wait cycle; unmapped offsets read zero
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            readdata_ff <= 32'h0000_0000;
        end else if (rd_take) begin
            case (i_avs_address)
                `OFS_STATUS:     readdata_ff <= status_word;
                `OFS_CORE_LEVEL: readdata_ff <= {25'h0, core_level_ff};
                `OFS_PLL_LEVEL:  readdata_ff <= {29'h0, pll_level_ff};
                `OFS_IRQ_STATUS: readdata_ff <= irq_status_ff;
                `OFS_IRQ_MASK:   readdata_ff <= irq_mask_ff;
                default:         readdata_ff <= 32'h0000_0000;
            endcase
        end
    end
    assign o_avs_readdata = readdata_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Level registers; strap defaults loaded once after reset release
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            core_level_ff <= `CORE_LEVEL_RST;
            pll_level_ff  <= `PLL_LEVEL_RST;
        end else if (strap_valid) begin
            core_level_ff <= core_default(strap);
            pll_level_ff  <= `PLL_LEVEL_RST + {1'b0, strap[3:2]};
        end else if (wr_take) begin
            // Ramp pacing is software's job; hardware applies at once
            if (i_avs_address == `OFS_CORE_LEVEL && i_avs_byteenable[0]) begin
                core_level_ff <= core_clamp(i_avs_writedata[6:0]);
            end
            if (i_avs_address == `OFS_PLL_LEVEL && i_avs_byteenable[0]) begin
                pll_level_ff <= i_avs_writedata[2:0];
            end
        end
    end
    assign o_core_rail_level = core_level_ff;
    assign o_pll_rail_level  = pll_level_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Any change of a status flag is an event; set wins over clear
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            flags_d_ff <= '0;
        end else begin
            flags_d_ff <= flags;
        end
    end
    assign rise_events = status_word ^ pack_status(flags_d_ff);

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            irq_status_ff <= 32'h0000_0000;
        end else begin
            logic [31:0] clr;
            clr = 32'h0000_0000;
            if (wr_take && i_avs_address == `OFS_IRQ_STATUS) begin
                clr = i_avs_writedata;
            end
            irq_status_ff <= ((irq_status_ff & ~clr) | rise_events)
                           & `STATUS_MASK;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            irq_mask_ff <= `IRQ_MASK_RST;
        end else if (wr_take && i_avs_address == `OFS_IRQ_MASK) begin
            irq_mask_ff <= i_avs_writedata & `STATUS_MASK;
        end
    end

    // Level interrupt from registered state only
    assign o_irq = |(irq_status_ff & irq_mask_ff);

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    // Status bits are compared with the flags one edge back, because the
    // read mux captures the word in the wait cycle, not at completion

    a_osc_bit_map: assert property (
        @(posedge i_clk_sys) disable iff (!i_resetn)
        rd_take && i_avs_address == `OFS_STATUS |=>
        o_avs_readdata[24] == $past(flags.osc_stable))
        else $error("oscillator bit wrong");
    a_pll_good_map: assert property (
        @(posedge i_clk_sys) disable iff (!i_resetn)
        rd_take && i_avs_address == `OFS_STATUS |=>
        o_avs_readdata[19] == $past(flags.pll_rail_good))
        else $error("pll good bit wrong");
    a_core_good_map: assert property (
        @(posedge i_clk_sys) disable iff (!i_resetn)
        rd_take && i_avs_address == `OFS_STATUS |=>
        o_avs_readdata[16] == $past(flags.core_rail_good))
        else $error("core good bit wrong");
    a_ilim_bits_map: assert property (
        @(posedge i_clk_sys) disable iff (!i_resetn)
        rd_take && i_avs_address == `OFS_STATUS |=>
        o_avs_readdata[9:8] == $past({flags.analogue_buck_converter_ilim,
                                      flags.core_buck_converter_ilim}))
        else $error("current limit bits wrong");
    a_soft_bits_map: assert property (
        @(posedge i_clk_sys) disable iff (!i_resetn)
        rd_take && i_avs_address == `OFS_STATUS |=>
        o_avs_readdata[1:0] == $past({flags.analogue_buck_converter_soft,
                                      flags.core_buck_converter_soft}))
        else $error("soft start bits wrong");
    a_reserved_zero: assert property (
        @(posedge i_clk_sys) disable iff (!i_resetn)
        rd_take && i_avs_address == `OFS_STATUS |=>
        (o_avs_readdata & ~`STATUS_MASK) == 32'h0000_0000)
        else $error("reserved status bits set");
    a_level_read_zero: assert property (
        @(posedge i_clk_sys) disable iff (!i_resetn)
        rd_take && (i_avs_address == `OFS_CORE_LEVEL
                    || i_avs_address == `OFS_PLL_LEVEL) |=>
        o_avs_readdata[31:7] == 25'h0)
        else $error("reserved level bits set");

    // Level registers: range, writes, PLL strap default and holding
    a_core_level_max: assert property (
        @(posedge i_clk_sys) disable iff (!i_resetn)
        core_level_ff <= `CORE_LEVEL_MAX)
        else $error("core level above 70");
    a_core_write_ok: assert property (
        @(posedge i_clk_sys) disable iff (!i_resetn)
        wr_take && !strap_valid && i_avs_byteenable[0]
        && i_avs_address == `OFS_CORE_LEVEL |=>
        core_level_ff == core_clamp($past(i_avs_writedata[6:0])))
        else $error("core level write lost");
    a_pll_write_ok: assert property (
        @(posedge i_clk_sys) disable iff (!i_resetn)
        wr_take && !strap_valid && i_avs_byteenable[0]
        && i_avs_address == `OFS_PLL_LEVEL |=>
        pll_level_ff == $past(i_avs_writedata[2:0]))
        else $error("pll level write lost");
    a_strap_default: assert property (
        @(posedge i_clk_sys) disable iff (!i_resetn)
        strap_valid |=>
        pll_level_ff == `PLL_LEVEL_RST + {1'b0, $past(strap[3:2])})
        else $error("strap default not loaded");
    // Without a write or a strap load the levels must not drift
    a_core_level_hold: assert property (
        @(posedge i_clk_sys) disable iff (!i_resetn)
        !strap_valid && !(wr_take && i_avs_address == `OFS_CORE_LEVEL) |=>
        $stable(core_level_ff))
        else $error("core level changed unasked");
    a_pll_level_hold: assert property (
        @(posedge i_clk_sys) disable iff (!i_resetn)
        !strap_valid && !(wr_take && i_avs_address == `OFS_PLL_LEVEL) |=>
        $stable(pll_level_ff))
        else $error("pll level changed unasked");

    // Handshake: exactly one wait cycle for every taken request
    a_wait_one_cycle: assert property (
        @(posedge i_clk_sys) disable iff (!i_resetn)
        rd_take || wr_take |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
        else $error("wait cycle count wrong");

    // Interrupt status: events always land, write-one clears otherwise
    a_event_sets_bit: assert property (
        @(posedge i_clk_sys) disable iff (!i_resetn)
        |rise_events |=>
        (irq_status_ff & $past(rise_events) & `STATUS_MASK)
        == ($past(rise_events) & `STATUS_MASK))
        else $error("flag event lost");
    a_irq_clear_ok: assert property (
        @(posedge i_clk_sys) disable iff (!i_resetn)
        wr_take && i_avs_address == `OFS_IRQ_STATUS
        && rise_events == 32'h0000_0000 |=>
        (irq_status_ff & $past(i_avs_writedata)) == 32'h0000_0000)
        else $error("interrupt clear ignored");

    c_status_read: cover property (
        @(posedge i_clk_sys) disable iff (!i_resetn)
        rd_take && i_avs_address == `OFS_STATUS);
    c_core_write: cover property (
        @(posedge i_clk_sys) disable iff (!i_resetn)
        wr_take && i_avs_address == `OFS_CORE_LEVEL);
    c_pll_write: cover property (
        @(posedge i_clk_sys) disable iff (!i_resetn)
        wr_take && i_avs_address == `OFS_PLL_LEVEL);
    c_irq_clear: cover property (
        @(posedge i_clk_sys) disable iff (!i_resetn)
        wr_take && i_avs_address == `OFS_IRQ_STATUS);
    c_irq_raise: cover property (
        @(posedge i_clk_sys) disable iff (!i_resetn)
        $rose(o_irq));
endmodule : power_supply_status_level_regs
`default_nettype wire

// File: tb/tb.sv
// Self-checking testbench for the supply status and level registers
`timescale 1ns/1ps
`default_nettype none
module tb
    import psu_regs_pkg::*;
;
    typedef struct packed {
        logic [6:0]  fl;
        logic [31:0] st;
    } row_type;

    logic             clk_sys;
    logic             resetn;
    logic [7:0]       address;
    logic             rd;
    logic             wr;
    logic [31:0]      wdata;
    logic [3:0]       be;
    logic [31:0]      rdata;
    logic             waitreq;
    supply_flags_type flags;
    logic [3:0]       strap;
    logic [6:0]       core_lvl;
    logic [2:0]       pll_lvl;
    logic             irq;
    logic [31:0]      dummy;
    int               fail_count = 0;
    int               check_count = 0;
    // One flag per row, then all on, then all off so every bit toggles
    row_type          rows [9] = '{
        '{7'h40, 32'h0100_0000}, '{7'h20, 32'h0008_0000},
        '{7'h10, 32'h0001_0000}, '{7'h08, 32'h0000_0200},
        '{7'h04, 32'h0000_0100}, '{7'h02, 32'h0000_0002},
        '{7'h01, 32'h0000_0001}, '{7'h7F, 32'h0109_0303},
        '{7'h00, 32'h0000_0000}};

    power_supply_status_level_regs power_supply_status_level_regs_i (
        .i_clk_sys         (clk_sys),
        .i_resetn          (resetn),
        .i_avs_address     (address),
        .i_avs_read        (rd),
        .i_avs_write       (wr),
        .i_avs_writedata   (wdata),
        .i_avs_byteenable  (be),
        .o_avs_readdata    (rdata),
        .o_avs_waitrequest (waitreq),
        .i_supply_flags    (flags),
        .i_mode_strap      (strap),
        .o_core_rail_level (core_lvl),
        .o_pll_rail_level  (pll_lvl),
        .o_irq             (irq)
    );

    ////////////////////////////////////////////////////////////////////////
    // 100 ns system clock
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Holds the request until waitrequest is seen low at a rising edge;
    // the negedge sample equals the edge value since inputs move at posedge
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] b,
                       output logic [31:0] q);
        logic wt;
        int   n;
        n = 0;
        @(posedge clk_sys);
        rd <= ~w;
        wr <= w;
        address <= a;
        wdata <= d;
        be <= b;
        do begin
            @(negedge clk_sys);
            wt = waitreq;
            q = rdata;
            @(posedge clk_sys);
            n++;
        end while (wt !== 1'b0 && n < 20);
        check("bus_answer", {31'h0, wt}, 32'h0);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus

    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF, dummy);
    endtask : wr32

    task automatic rd_chk(input string what, input logic [7:0] a,
                          input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 4'hF, q);
        check(what, q, exp);
    endtask : rd_chk

    // One code per write, 1.3 microseconds (13 cycles) apart, so the rail never slews
    // faster than one step per microsecond; reserved bits set on purpose
    task automatic ramp_core(input logic [6:0] from, input logic [6:0] to);
        logic [6:0] c;
        c = from;
        while (c != to) begin
            c = (c < to) ? c + 7'h01 : c - 7'h01;
            wr32(8'h34, {25'h1FF_FFFF, c});
            repeat (10) @(posedge clk_sys);
        end
    endtask : ramp_core

    task automatic set_flags(input logic [6:0] f);
        @(posedge clk_sys);
        flags <= f;
        repeat (5) @(posedge clk_sys);
    endtask : set_flags

    // Straps are applied with reset; first request comes well after load
    task automatic do_reset(input logic [3:0] s);
        @(posedge clk_sys);
        resetn <= 1'b0;
        strap <= s;
        repeat (15) @(posedge clk_sys);
        @(negedge clk_sys);
        check("rst_core", {25'h0, core_lvl}, 32'h28);
        check("rst_pll", {29'h0, pll_lvl}, 32'h4);
        check("rst_irq", {31'h0, irq}, 32'h0);
        @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (6) @(posedge clk_sys);
    endtask : do_reset

    ////////////////////////////////////////////////////////////////////////
    // Watchdog, far beyond the roughly 1300 cycles the run needs
    initial begin
        #2_000_000;
        fail_count++;
        conclude();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        resetn = 1'b0;
        address = 8'h00;
        rd = 1'b0;
        wr = 1'b0;
        wdata = 32'h0;
        be = 4'hF;
        flags = '0;
        strap = 4'h0;
        do_reset(4'b1001);
        rd_chk("core_default", 8'h34, 32'h0000_0038);
        rd_chk("pll_default", 8'h40, 32'h0000_0006);
        rd_chk("mask_reset", 8'h48, 32'h0000_0000);
        $display("reset test done");
        // Status table: each flag lands at its own bit only
        for (int i = 0; i < 9; i++) begin
            set_flags(rows[i].fl);
            rd_chk("status", 8'h30, rows[i].st);
        end
        $display("status table done");
        // Level registers, boundaries and reserved bits
        ramp_core(7'h38, 7'h45);
        rd_chk("core_69", 8'h34, 32'h0000_0045);
        check("core_pin", {25'h0, core_lvl}, 32'h45);
        ramp_core(7'h45, 7'h46);
        rd_chk("core_70", 8'h34, 32'h0000_0046);
        wr32(8'h34, 32'h0000_0047);
        repeat (10) @(posedge clk_sys);
        rd_chk("core_clamp", 8'h34, 32'h0000_0046);
        ramp_core(7'h46, 7'h00);
        rd_chk("core_0", 8'h34, 32'h0000_0000);
        bus(1'b1, 8'h34, 32'h0000_0001, 4'hE, dummy);
        rd_chk("core_no_lane", 8'h34, 32'h0000_0000);
        wr32(8'h40, 32'hFFFF_FFFF);
        rd_chk("pll_7", 8'h40, 32'h0000_0007);
        check("pll_pin", {29'h0, pll_lvl}, 32'h7);
        wr32(8'h40, 32'h0000_0003);
        rd_chk("pll_3", 8'h40, 32'h0000_0003);
        wr32(8'h30, 32'hFFFF_FFFF);
        rd_chk("status_ro", 8'h30, 32'h0000_0000);
        rd_chk("unmapped", 8'h50, 32'h0000_0000);
        $display("level test done");
        // Interrupt: every bit toggled in the table, all masked so far
        check("irq_masked", {31'h0, irq}, 32'h0);
        rd_chk("irq_all", 8'h44, 32'h0109_0303);
        wr32(8'h48, 32'h0100_0000);
        check("irq_on", {31'h0, irq}, 32'h1);
        wr32(8'h44, 32'h0100_0000);
        check("irq_off", {31'h0, irq}, 32'h0);
        rd_chk("irq_rest", 8'h44, 32'h0009_0303);
        wr32(8'h44, 32'hFFFF_FFFF);
        rd_chk("irq_clear", 8'h44, 32'h0000_0000);
        set_flags(7'h01);
        check("irq_other", {31'h0, irq}, 32'h0);
        rd_chk("irq_soft", 8'h44, 32'h0000_0001);
        set_flags(7'h41);
        check("irq_osc", {31'h0, irq}, 32'h1);
        $display("interrupt test done");
        // Second reset with straps that push the core default past 70
        do_reset(4'b0111);
        rd_chk("core_strap2", 8'h34, 32'h0000_0046);
        rd_chk("pll_strap2", 8'h40, 32'h0000_0005);
        rd_chk("mask_reset2", 8'h48, 32'h0000_0000);
        $display("second reset test done");
        conclude();
    end
endmodule : tb
`default_nettype wire
